// >>> rtl/iotu_pkg.sv
package iotu_pkg;
    // Register byte addresses
    localparam logic [35:0] CTRL_ADDR = 36'hfe0000000;
    localparam logic [35:0] TABLE_BASE_ADDR = 36'hfe0000004;
    localparam logic [35:0] FLUSH_ALL_ADDR = 36'hfe0000014;
    localparam logic [35:0] FLUSH_PAGE_ADDR = 36'hfe0000018;
    localparam logic [35:0] SLOT_CFG_BASE = 36'hfe0000020;
    localparam logic [35:0] TAG_WIN_BASE = 36'hfe0000100;
    localparam logic [35:0] DIAG_VA_ADDR = 36'hfe0000140;
    localparam logic [35:0] DIAG_CMP_ADDR = 36'hfe0000150;
    localparam logic [35:0] DATA_WIN_BASE = 36'hfe0000200;
    localparam logic [35:0] WIN_MASK = 36'hfffffffc0;
    // Cache geometry
    localparam int ENTRIES = 16;
    localparam int IDX_W = 4;
    localparam int TAG_W = 19;
    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DIAG_BIT = 1;
    localparam int CTRL_RANGE_LSB = 2;
    localparam int RANGE_W = 3;
    localparam int WIN_TOP_BASE = 23;
    // Table entry and cache data fields
    localparam int ENT_V_BIT = 1;
    localparam int ENT_W_BIT = 2;
    localparam int ENT_C_BIT = 7;
    localparam int PPN_LSB = 8;
    // Slot configuration fields
    localparam int SLOT_BYP_BIT = 0;
    localparam int SLOT_COH_BIT = 1;
    localparam int SLOT_WIDE_BIT = 2;
    localparam int SLOT_SEG_LSB = 16;
    // Bypass function select value
    localparam logic [5:0] FUNC_SLOT_CFG = 6'h00;
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h00000000;

    typedef struct packed {
        logic [23:0] phys_page_number;
        logic c;
        logic w;
        logic v;
    } entry_s;

    typedef struct packed {
        logic [5:0] seg;
        logic wide;
        logic coh;
        logic byp;
    } slot_cfg_s;

    typedef struct packed {
        logic ack;
        logic err;
        logic [35:0] pa;
        logic cacheable;
        logic coherent;
        logic [31:0] rdata;
    } device_virtual_access_rsp_s;
endpackage

// >>> rtl/io_translation_unit.sv
`timescale 1ns/1ps
module io_translation_unit
    import iotu_pkg::*;
#(
    parameter int SLOTS = 4,
    localparam int SW = $clog2(SLOTS)
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic [35:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Device virtual access from I/O masters
    input wire logic DEVICE_VIRTUAL_ACCESS_REQ,
    input wire logic [SW-1:0] DEVICE_VIRTUAL_ACCESS_SLOT,
    input wire logic [31:0] DEVICE_VIRTUAL_ACCESS_VA,
    input wire logic DEVICE_VIRTUAL_ACCESS_WRITE,
    input wire logic [31:0] DEVICE_VIRTUAL_ACCESS_WDATA,
    output device_virtual_access_rsp_s DEVICE_VIRTUAL_ACCESS_RSP,
    // Table walk memory port
    output logic MEM_REQ,
    output logic [35:0] MEM_ADDR,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    // Processor to slave transfers
    input wire logic PIO_REQ,
    input wire logic [SW-1:0] PIO_SLOT,
    input wire logic [35:0] PIO_ADDR,
    input wire logic [4:0] PIO_WORDS,
    output logic PIO_DONE,
    output logic SLV_REQ,
    output logic [35:0] SLV_ADDR,
    output logic SLV_WIDE,
    input wire logic SLV_ACK
);
    typedef enum {S_IDLE, S_WALK} walk_e;
    typedef enum {P_IDLE, P_ISSUE, P_WAIT} pio_e;

    walk_e state_q;
    pio_e pstate_q;
    logic [31:0] ctrl_q;
    logic [23:0] table_base_q;
    logic [31:0] diag_va_q;
    logic [ENTRIES-1:0] cmp_q;
    slot_cfg_s slot_q [SLOTS];
    logic [TAG_W-1:0] tag_q [ENTRIES];
    entry_s ent_q [ENTRIES];
    logic [IDX_W-1:0] lru_q [ENTRIES];
    logic [31:0] va_q;
    logic wr_q;
    logic [35:0] paddr_q;
    logic [4:0] left_q;
    logic wide_q;

    logic ctrl_en, diag_en, take, byp_phys, byp_func, in_win, hit_any;
    logic [4:0] win_top;
    logic [31:0] hi_mask, lo_mask;
    logic [35:0] pte_addr;
    logic [ENTRIES-1:0] hit_vec, pg_match;
    logic [IDX_W-1:0] hit_idx, lru_pos, touch_idx;
    logic touch_en, fill_en;
    slot_cfg_s cur_slot;
    entry_s pte;
    logic win_tag, win_dat;
    logic [IDX_W-1:0] win_idx;

    assign ctrl_en = ctrl_q[CTRL_EN_BIT];
    assign diag_en = ctrl_q[CTRL_DIAG_BIT];
    assign cur_slot = slot_q[DEVICE_VIRTUAL_ACCESS_SLOT];
    assign take = state_q == S_IDLE && DEVICE_VIRTUAL_ACCESS_REQ && !DEVICE_VIRTUAL_ACCESS_RSP.ack && !DEVICE_VIRTUAL_ACCESS_RSP.err;
    assign byp_phys = cur_slot.byp && DEVICE_VIRTUAL_ACCESS_VA[31:30] == 2'b00;
    assign byp_func = cur_slot.byp && DEVICE_VIRTUAL_ACCESS_VA[31:30] == 2'b01;
    assign pte = '{phys_page_number: MEM_RDATA[31:PPN_LSB], c: MEM_RDATA[ENT_C_BIT],
                   w: MEM_RDATA[ENT_W_BIT], v: MEM_RDATA[ENT_V_BIT]};
    assign win_idx = REG_ADDR[5:2];
    assign win_tag = (REG_ADDR & WIN_MASK) == TAG_WIN_BASE;
    assign win_dat = (REG_ADDR & WIN_MASK) == DATA_WIN_BASE;

    // Window size and table entry address from the range field
    always_comb begin
        win_top = 5'(WIN_TOP_BASE) + 5'(ctrl_q[CTRL_RANGE_LSB +: RANGE_W]);
        lo_mask = (32'h2 << win_top) - 32'h1;
        hi_mask = ~lo_mask;
        in_win = (DEVICE_VIRTUAL_ACCESS_VA & hi_mask) == hi_mask;
        // Base bits below the table size are ignored, so the table is size aligned
        pte_addr = ({table_base_q, 12'h000} & ~{14'h0000, lo_mask[31:10]})
                   | {14'h0000, 22'((va_q & lo_mask) >> 10)};
        pte_addr[1:0] = 2'b00;
    end

    // Tag lookup, page flush match and LRU position
    always_comb begin
        hit_idx = '0;
        lru_pos = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            hit_vec[i] = ent_q[i].v && tag_q[i] == DEVICE_VIRTUAL_ACCESS_VA[30:12];
            pg_match[i] = tag_q[i] == REG_WDATA[30:12];
            if (hit_vec[i]) begin
                hit_idx = IDX_W'(i);
            end
            if (lru_q[i] == touch_idx) begin
                lru_pos = IDX_W'(i);
            end
        end
        hit_any = |hit_vec;
    end

    // A walk that returns a valid, permitted entry fills the least recently used slot
    assign fill_en = state_q == S_WALK && MEM_ACK && pte.v && !(wr_q && !pte.w);
    assign touch_en = fill_en
        || (take && !byp_phys && !byp_func && ctrl_en && in_win && hit_any
            && !(DEVICE_VIRTUAL_ACCESS_WRITE && !ent_q[hit_idx].w));
    assign touch_idx = fill_en ? lru_q[0] : hit_idx;

    // LRU queue: position 0 is the victim, the top is most recent
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < ENTRIES; i++) begin
                lru_q[i] <= IDX_W'(i);
            end
        end else if (touch_en) begin
            for (int i = 0; i < ENTRIES - 1; i++) begin
                if (IDX_W'(i) >= lru_pos) begin
                    lru_q[i] <= lru_q[i+1];
                end
            end
            lru_q[ENTRIES-1] <= touch_idx;
        end
    end

    // Tag and data arrays; flushes come last so they win over a fill
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < ENTRIES; i++) begin
                ent_q[i] <= '0;
                tag_q[i] <= '0;
            end
        end else begin
            if (fill_en) begin
                tag_q[lru_q[0]] <= va_q[30:12];
                ent_q[lru_q[0]] <= pte;
            end
            if (REG_WR && diag_en && win_tag) begin
                tag_q[win_idx] <= REG_WDATA[30:12];
            end
            if (REG_WR && diag_en && win_dat) begin
                ent_q[win_idx] <= '{phys_page_number: REG_WDATA[31:PPN_LSB], c: REG_WDATA[ENT_C_BIT],
                                    w: REG_WDATA[ENT_W_BIT], v: REG_WDATA[ENT_V_BIT]};
            end
            for (int i = 0; i < ENTRIES; i++) begin
                if (REG_WR && REG_ADDR == FLUSH_ALL_ADDR) begin
                    ent_q[i].v <= 1'b0;
                end
                if (REG_WR && REG_ADDR == FLUSH_PAGE_ADDR && pg_match[i]) begin
                    ent_q[i].v <= 1'b0;
                end
            end
        end
    end

    // Control, table base and diagnostic address registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_q <= CTRL_RESET;
            table_base_q <= '0;
            diag_va_q <= '0;
        end else if (REG_WR) begin
            if (REG_ADDR == CTRL_ADDR) begin
                ctrl_q <= REG_WDATA & 32'h0000001f;
            end
            if (REG_ADDR == TABLE_BASE_ADDR) begin
                table_base_q <= REG_WDATA[31:PPN_LSB];
            end
            if (REG_ADDR == DIAG_VA_ADDR) begin
                diag_va_q <= REG_WDATA;
            end
        end
    end

    // Comparator outputs, refreshed every cycle in diagnostic mode
    always_ff @(posedge CLK) begin
        if (RST) begin
            cmp_q <= '0;
        end else begin
            for (int i = 0; i < ENTRIES; i++) begin
                cmp_q[i] <= diag_en && tag_q[i] == diag_va_q[30:12];
            end
        end
    end

    // Slot configuration: software writes all, a master only seg and coh of its own slot
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < SLOTS; i++) begin
                if (REG_WR && REG_ADDR == SLOT_CFG_BASE + 36'(4 * i)) begin
                    slot_q[i] <= '{seg: REG_WDATA[SLOT_SEG_LSB +: 6],
                                   wide: REG_WDATA[SLOT_WIDE_BIT],
                                   coh: REG_WDATA[SLOT_COH_BIT],
                                   byp: REG_WDATA[SLOT_BYP_BIT]};
                end
            end
            if (take && byp_func && DEVICE_VIRTUAL_ACCESS_WRITE && DEVICE_VIRTUAL_ACCESS_VA[29:24] == FUNC_SLOT_CFG) begin
                slot_q[DEVICE_VIRTUAL_ACCESS_SLOT].seg <= DEVICE_VIRTUAL_ACCESS_WDATA[SLOT_SEG_LSB +: 6];
                slot_q[DEVICE_VIRTUAL_ACCESS_SLOT].coh <= DEVICE_VIRTUAL_ACCESS_WDATA[SLOT_COH_BIT];
            end
        end
    end

    // Register read data, valid only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (RST || !REG_RD) begin
            REG_RDATA <= '0;
        end else if (REG_ADDR == CTRL_ADDR) begin
            REG_RDATA <= ctrl_q;
        end else if (REG_ADDR == TABLE_BASE_ADDR) begin
            REG_RDATA <= {table_base_q, 8'h00};
        end else if (REG_ADDR == DIAG_CMP_ADDR) begin
            REG_RDATA <= {16'h0000, cmp_q};
        end else if (diag_en && win_tag) begin
            REG_RDATA <= {1'b0, tag_q[win_idx], 8'h00, lru_q[win_idx]};
        end else if (diag_en && win_dat) begin
            REG_RDATA <= {ent_q[win_idx].phys_page_number, ent_q[win_idx].c, 4'h0,
                          ent_q[win_idx].w, ent_q[win_idx].v, 1'b0};
        end else begin
            REG_RDATA <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                if (REG_ADDR == SLOT_CFG_BASE + 36'(4 * i)) begin
                    REG_RDATA <= {10'h000, slot_q[i].seg, 13'h0000, slot_q[i].wide,
                                  slot_q[i].coh, slot_q[i].byp};
                end
            end
        end
    end

    // Master access handling and table walk
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= S_IDLE;
            DEVICE_VIRTUAL_ACCESS_RSP <= '0;
            MEM_REQ <= 1'b0;
            MEM_ADDR <= '0;
            va_q <= '0;
            wr_q <= 1'b0;
        end else begin
            DEVICE_VIRTUAL_ACCESS_RSP <= '0;
            case (state_q)
                S_IDLE: begin
                    if (take && byp_phys) begin
                        // No VA superset is known, so never cacheable
                        DEVICE_VIRTUAL_ACCESS_RSP.pa <= {cur_slot.seg, DEVICE_VIRTUAL_ACCESS_VA[29:0]};
                        DEVICE_VIRTUAL_ACCESS_RSP.coherent <= cur_slot.coh;
                        DEVICE_VIRTUAL_ACCESS_RSP.err <= cur_slot.seg != 6'h00;
                        DEVICE_VIRTUAL_ACCESS_RSP.ack <= cur_slot.seg == 6'h00;
                    end else if (take && byp_func) begin
                        DEVICE_VIRTUAL_ACCESS_RSP.err <= DEVICE_VIRTUAL_ACCESS_VA[29:24] != FUNC_SLOT_CFG;
                        DEVICE_VIRTUAL_ACCESS_RSP.ack <= DEVICE_VIRTUAL_ACCESS_VA[29:24] == FUNC_SLOT_CFG;
                        DEVICE_VIRTUAL_ACCESS_RSP.rdata <= {10'h000, cur_slot.seg, 13'h0000, cur_slot.wide,
                                           cur_slot.coh, cur_slot.byp};
                    end else if (take && (!ctrl_en || !in_win)) begin
                        DEVICE_VIRTUAL_ACCESS_RSP.err <= 1'b1;
                    end else if (take && hit_any) begin
                        DEVICE_VIRTUAL_ACCESS_RSP.pa <= {ent_q[hit_idx].phys_page_number, DEVICE_VIRTUAL_ACCESS_VA[11:0]};
                        DEVICE_VIRTUAL_ACCESS_RSP.cacheable <= ent_q[hit_idx].c;
                        DEVICE_VIRTUAL_ACCESS_RSP.coherent <= ent_q[hit_idx].c;
                        DEVICE_VIRTUAL_ACCESS_RSP.err <= DEVICE_VIRTUAL_ACCESS_WRITE && !ent_q[hit_idx].w;
                        DEVICE_VIRTUAL_ACCESS_RSP.ack <= !(DEVICE_VIRTUAL_ACCESS_WRITE && !ent_q[hit_idx].w);
                    end else if (take) begin
                        va_q <= DEVICE_VIRTUAL_ACCESS_VA;
                        wr_q <= DEVICE_VIRTUAL_ACCESS_WRITE;
                        state_q <= S_WALK;
                    end
                end
                S_WALK: begin
                    MEM_REQ <= !MEM_ACK;
                    MEM_ADDR <= pte_addr;
                    if (MEM_ACK) begin
                        DEVICE_VIRTUAL_ACCESS_RSP.pa <= {pte.phys_page_number, va_q[11:0]};
                        DEVICE_VIRTUAL_ACCESS_RSP.cacheable <= pte.c;
                        DEVICE_VIRTUAL_ACCESS_RSP.coherent <= pte.c;
                        DEVICE_VIRTUAL_ACCESS_RSP.ack <= fill_en;
                        DEVICE_VIRTUAL_ACCESS_RSP.err <= !fill_en;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Processor transfers: wide slots take 64-bit pieces when 8-byte aligned with two or more words left, otherwise single words
    always_ff @(posedge CLK) begin
        if (RST) begin
            pstate_q <= P_IDLE;
            SLV_REQ <= 1'b0;
            SLV_ADDR <= '0;
            SLV_WIDE <= 1'b0;
            PIO_DONE <= 1'b0;
            paddr_q <= '0;
            left_q <= '0;
            wide_q <= 1'b0;
        end else begin
            PIO_DONE <= 1'b0;
            case (pstate_q)
                P_IDLE: begin
                    if (PIO_REQ && !PIO_DONE && PIO_WORDS != 5'h00) begin
                        paddr_q <= PIO_ADDR;
                        left_q <= PIO_WORDS;
                        wide_q <= slot_q[PIO_SLOT].wide;
                        pstate_q <= P_ISSUE;
                    end
                end
                P_ISSUE: begin
                    SLV_REQ <= 1'b1;
                    SLV_ADDR <= paddr_q;
                    SLV_WIDE <= wide_q && left_q >= 5'h02 && paddr_q[2:0] == 3'h0;
                    pstate_q <= P_WAIT;
                end
                P_WAIT: begin
                    if (SLV_ACK) begin
                        SLV_REQ <= 1'b0;
                        paddr_q <= paddr_q + (SLV_WIDE ? 36'h8 : 36'h4);
                        left_q <= left_q - (SLV_WIDE ? 5'h02 : 5'h01);
                        if (left_q == (SLV_WIDE ? 5'h02 : 5'h01)) begin
                            PIO_DONE <= 1'b1;
                            pstate_q <= P_IDLE;
                        end else begin
                            pstate_q <= P_ISSUE;
                        end
                    end
                end
                default: pstate_q <= P_IDLE;
            endcase
        end
    end

    // Checks on the documented behaviour
    sequence s_bad_pte;
        state_q == S_WALK && MEM_ACK && !MEM_RDATA[ENT_V_BIT];
    endsequence

    a_flush_all_clears: assert property (@(posedge CLK) disable iff (RST)
        REG_WR && REG_ADDR == FLUSH_ALL_ADDR |=> !ent_q[0].v && !ent_q[ENTRIES-1].v)
        else $error("flush all left an entry valid");
    a_page_flush_clears: assert property (@(posedge CLK) disable iff (RST)
        REG_WR && REG_ADDR == FLUSH_PAGE_ADDR && pg_match[0] |=> !ent_q[0].v)
        else $error("page flush left matching entry valid");
    a_hit_no_walk: assert property (@(posedge CLK) disable iff (RST)
        take && hit_any && !byp_phys && !byp_func |=> state_q == S_IDLE ##1 !MEM_REQ)
        else $error("table fetched on a cache hit");
    a_entry_address: assert property (@(posedge CLK) disable iff (RST)
        MEM_REQ |-> MEM_ADDR[1:0] == 2'b00 && MEM_ADDR[11:2] == va_q[21:12])
        else $error("table entry address malformed");
    a_bypass_address: assert property (@(posedge CLK) disable iff (RST)
        take && byp_phys |=> DEVICE_VIRTUAL_ACCESS_RSP.pa == {$past(cur_slot.seg), $past(DEVICE_VIRTUAL_ACCESS_VA[29:0])})
        else $error("bypass address malformed");
    a_bypass_range_err: assert property (@(posedge CLK) disable iff (RST)
        take && byp_phys && cur_slot.seg != 6'h00 |=> DEVICE_VIRTUAL_ACCESS_RSP.err && !DEVICE_VIRTUAL_ACCESS_RSP.ack)
        else $error("bypass outside memory not refused");
    a_func_select_err: assert property (@(posedge CLK) disable iff (RST)
        take && byp_func && DEVICE_VIRTUAL_ACCESS_VA[29:24] != FUNC_SLOT_CFG |=> DEVICE_VIRTUAL_ACCESS_RSP.err)
        else $error("bad function select not refused");
    a_window_err: assert property (@(posedge CLK) disable iff (RST)
        take && !byp_phys && !byp_func && !in_win |=> DEVICE_VIRTUAL_ACCESS_RSP.err && !MEM_REQ)
        else $error("address outside window not refused");
    a_bad_pte_err: assert property (@(posedge CLK) disable iff (RST)
        s_bad_pte |=> DEVICE_VIRTUAL_ACCESS_RSP.err && state_q == S_IDLE ##1 !MEM_REQ)
        else $error("invalid table entry not refused");
endmodule // io_translation_unit

// >>> verif/iotu_far_model.sv
`timescale 1ns/1ps
module iotu_far_model (
    // Clock
    input wire logic clk,
    // Table memory side
    input wire logic mem_req,
    input wire logic [35:0] mem_addr,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    // Slave side
    input wire logic slv_req,
    input wire logic slv_wide,
    output logic slv_ack,
    // Pace and activity counts
    input wire logic slow,
    output logic [35:0] fetches,
    output logic [35:0] pieces,
    output logic [35:0] wides
);
    logic [3:0] wait_q;

    initial begin
        {mem_ack, slv_ack, wait_q, mem_rdata} = '0;
        {fetches, pieces, wides} = '0;
    end

    // Entry valid unless VA bit 14, read-only when VA bit 13; idle data churns
    always @(posedge clk) begin
        mem_ack <= 1'h0;
        if (mem_req && !mem_ack) begin
            if (wait_q == (slow ? 4'h5 : 4'h0)) begin
                mem_ack <= 1'h1;
                mem_rdata <= {12'h05a, mem_addr[13:2], 5'h10, !mem_addr[3], !mem_addr[4], 1'h0};
                fetches <= fetches + 36'h1;
                wait_q <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else if (!mem_ack) begin
            mem_rdata <= ~mem_rdata;
        end
    end

    // Slave answers each piece one cycle after it is offered
    always @(posedge clk) begin
        slv_ack <= slv_req && !slv_ack;
        if (slv_req && slv_ack) begin
            pieces <= pieces + 36'h1;
            wides <= wides + 36'(slv_wide);
        end
    end
endmodule // iotu_far_model

// >>> verif/io_translation_unit_bench.sv
`timescale 1ns/1ps
module io_translation_unit_bench import iotu_pkg::*; ();
    logic clk, rst, reg_wr, reg_rd, device_virtual_access_req, device_virtual_access_write, pio_req, mem_ack, slv_ack, slow;
    logic mem_req, slv_req, slv_wide, pio_done;
    logic [35:0] reg_addr, mem_addr, pio_addr, slv_addr, fetches, pieces, wides, seen, last, n;
    logic [31:0] reg_wdata, reg_rdata, device_virtual_access_va, device_virtual_access_wdata, mem_rdata, rd_v;
    logic [1:0] device_virtual_access_slot, pio_slot;
    logic [4:0] pio_words;
    device_virtual_access_rsp_s rsp, got;
    int errors = 0;
    int comparisons = 0;
    localparam logic [35:0] TB = 36'h010000000;

    io_translation_unit dut_u (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .DEVICE_VIRTUAL_ACCESS_REQ(device_virtual_access_req),
        .DEVICE_VIRTUAL_ACCESS_SLOT(device_virtual_access_slot), .DEVICE_VIRTUAL_ACCESS_VA(device_virtual_access_va), .DEVICE_VIRTUAL_ACCESS_WRITE(device_virtual_access_write),
        .DEVICE_VIRTUAL_ACCESS_WDATA(device_virtual_access_wdata), .DEVICE_VIRTUAL_ACCESS_RSP(rsp), .MEM_REQ(mem_req), .MEM_ADDR(mem_addr),
        .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .PIO_REQ(pio_req), .PIO_SLOT(pio_slot),
        .PIO_ADDR(pio_addr), .PIO_WORDS(pio_words), .PIO_DONE(pio_done), .SLV_REQ(slv_req),
        .SLV_ADDR(slv_addr), .SLV_WIDE(slv_wide), .SLV_ACK(slv_ack));
    iotu_far_model far_u (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .slv_req(slv_req), .slv_wide(slv_wide), .slv_ack(slv_ack),
        .slow(slow), .fetches(fetches), .pieces(pieces), .wides(wides));

    // Last fetch and piece addresses offered
    always @(posedge clk) begin
        if (mem_req) seen <= mem_addr;
        if (slv_req) last <= slv_addr;
    end

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [35:0] s, input logic [35:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic final_report();
        $display("Mismatches %0d of %0d comparisons", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Register bus: extra cycle after each strobe keeps one assignment per step
    task automatic wr(input logic [35:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [35:0] a);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 rd_v = reg_rdata;
        @(posedge clk);
    endtask

    // Master access held until ack or err is seen; r is {ack, err}
    task automatic dv(input logic [1:0] s, input logic [31:0] va, input logic w,
                      input logic [1:0] r);
        device_virtual_access_slot <= s;
        device_virtual_access_va <= va;
        device_virtual_access_write <= w;
        device_virtual_access_req <= 1'h1;
        got = '0;
        for (int i = 0; i < 40 && !(got.ack || got.err); i++) begin
            @(posedge clk);
            #1 got = rsp;
        end
        @(posedge clk);
        device_virtual_access_req <= 1'h0;
        @(posedge clk);
        check(36'({got.ack, got.err}), 36'(r));
    endtask

    task automatic pio(input logic [1:0] s, input logic [35:0] a, input logic [4:0] w);
        pio_slot <= s;
        pio_addr <= a;
        pio_words <= w;
        pio_req <= 1'h1;
        for (int i = 0; i < 100 && pio_done !== 1'h1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        pio_req <= 1'h0;
        @(posedge clk);
    endtask

    task automatic s_translate();
        wr(TABLE_BASE_ADDR, 32'h01000000);
        wr(CTRL_ADDR, 32'h00000001);
        slow <= 1'h1;
        dv(2'h0, 32'hff001234, 1'h0, 2'h2);
        check(got.pa, 36'h05a001234);
        check(seen, TB + 36'h4);
        check(36'(got.cacheable), 36'h1);
        slow <= 1'h0;
        n = fetches;
        dv(2'h0, 32'hff001ffc, 1'h1, 2'h2);
        check(fetches, n);
        dv(2'h0, 32'hfe001000, 1'h0, 2'h1);
        dv(2'h0, 32'h7f001000, 1'h0, 2'h1);
        dv(2'h0, 32'hff004000, 1'h0, 2'h1);
        dv(2'h0, 32'hff004000, 1'h0, 2'h1);
        check(fetches, n + 36'h2);
        dv(2'h0, 32'hff002000, 1'h1, 2'h1);
        dv(2'h0, 32'hff002000, 1'h0, 2'h2);
    endtask

    task automatic s_flush();
        n = fetches;
        wr(FLUSH_PAGE_ADDR, 32'hff001000);
        dv(2'h0, 32'hff001000, 1'h0, 2'h2);
        dv(2'h0, 32'hff002000, 1'h0, 2'h2);
        check(fetches, n + 36'h1);
        wr(FLUSH_ALL_ADDR, 32'h00000000);
        dv(2'h0, 32'hff001000, 1'h0, 2'h2);
        dv(2'h0, 32'hff002000, 1'h0, 2'h2);
        check(fetches, n + 36'h3);
        // Seventeen pages push the oldest out
        for (int i = 0; i < 17; i++) dv(2'h0, 32'hff100000 + i * 32'h8000, 1'h0, 2'h2);
        check(seen, TB + 36'h600);
        n = fetches;
        dv(2'h0, 32'hff180000, 1'h0, 2'h2);
        dv(2'h0, 32'hff100000, 1'h0, 2'h2);
        check(fetches, n + 36'h1);
    endtask

    task automatic s_bypass();
        wr(SLOT_CFG_BASE + 36'h4, 32'h00000003);
        dv(2'h1, 32'h12345678, 1'h0, 2'h2);
        check(got.pa, 36'h012345678);
        check(36'({got.cacheable, got.coherent}), 36'h1);
        dv(2'h1, 32'hff180abc, 1'h0, 2'h2);
        check(got.pa, 36'h05a180abc);
        wr(SLOT_CFG_BASE + 36'h4, 32'h00010003);
        dv(2'h1, 32'h00000000, 1'h0, 2'h1);
        dv(2'h1, 32'h40000000, 1'h0, 2'h2);
        check(36'(got.rdata), 36'h00010003);
        dv(2'h1, 32'h41000000, 1'h0, 2'h1);
        device_virtual_access_wdata <= 32'h00000004;
        dv(2'h1, 32'h40000000, 1'h1, 2'h2);
        rd(SLOT_CFG_BASE + 36'h4);
        check(36'(rd_v), 36'h00000001);
    endtask

    task automatic s_diag();
        wr(CTRL_ADDR, 32'h00000002);
        wr(TAG_WIN_BASE + 36'hc, 32'h00abc000);
        wr(DATA_WIN_BASE + 36'hc, 32'hdeadbeef);
        wr(DIAG_VA_ADDR, 32'h80abc000);
        wr(DIAG_CMP_ADDR, 32'hffffffff);
        rd(TAG_WIN_BASE + 36'hc);
        check(36'(rd_v & 32'hfffff000), 36'h00abc000);
        rd(DATA_WIN_BASE + 36'hc);
        check(36'(rd_v), 36'hdeadbe86);
        rd(DIAG_CMP_ADDR);
        check(36'(rd_v), 36'h00000008);
        rd(36'hfe0000ffc);
        check(36'(rd_v), 36'h0);
    endtask

    // Wide slot, misaligned start and narrow slot
    task automatic s_pio();
        wr(SLOT_CFG_BASE + 36'h8, 32'h00000004);
        pio(2'h2, 36'h000100008, 5'h4);
        check({4'h0, pieces[3:0], wides[3:0], last[23:0]}, 36'h022100010);
        pio(2'h2, 36'h000100004, 5'h3);
        check({4'h0, pieces[3:0], wides[3:0], last[23:0]}, 36'h043100008);
        pio(2'h0, 36'h000100000, 5'h3);
        check({4'h0, pieces[3:0], wides[3:0], last[23:0]}, 36'h073100008);
    endtask

    initial begin
        {reg_wr, reg_rd, device_virtual_access_req, device_virtual_access_write, pio_req, slow, device_virtual_access_slot, pio_slot} = '0;
        {reg_addr, pio_addr, reg_wdata, device_virtual_access_va, device_virtual_access_wdata, pio_words} = '0;
        rst = 1'h1;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        s_translate();
        s_flush();
        s_bypass();
        s_diag();
        s_pio();
        final_report();
    end

    // Hang guard well past the expected run
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule // io_translation_unit_bench
